// *** pkg/lpw_pkg.sv ***
// Purpose: Shared constants and types for the low-power wake-up controller.
// Assumes: 20 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes: All offsets, field positions and timing counts live here, plus the timer enable and expiry status reset values.
package lpw_pkg;

    // Register byte offsets.
    localparam logic [3:0] LPW_OFS_CTRL = 4'h0;
    localparam logic [3:0] LPW_OFS_STAT = 4'h4;
    localparam logic [3:0] LPW_OFS_WAKE = 4'h8;

    // Control register field positions.
    localparam int LPW_CTRL_MODE_LO = 0;
    localparam int LPW_CTRL_GEAR = 2;
    localparam int LPW_CTRL_PWR_EN = 3;
    localparam int LPW_CTRL_LOCK = 4;
    localparam int LPW_CTRL_ONE2ONE = 5;
    localparam int LPW_CTRL_TIMER_EN_LO = 8;

    // Status register field positions.
    localparam int LPW_STAT_TIRQ = 0;
    localparam int LPW_STAT_TIMER_EXPIRY_PIN = 1;
    localparam int LPW_STAT_STATE_LO = 8;

    // Mode field encodings.
    localparam logic [1:0] LPW_MODE_NORMAL = 2'h0;
    localparam logic [1:0] LPW_MODE_DOZE = 2'h1;
    localparam logic [1:0] LPW_MODE_SLEEP = 2'h2;
    localparam logic [1:0] LPW_MODE_DEEP = 2'h3;

    // Timer source bit order: real-time clock, periodic timer, time base, decrementer.
    localparam int LPW_NUM_TIMERS = 4;
    localparam logic [3:0] LPW_TIMER_EN_RST = 4'h0;
    localparam logic LPW_TIMER_EXPIRY_PIN_RST = 1'b1;

    // Wake-up latencies. Clock is the maximum system frequency here.
    localparam int LPW_CLK_MHZ = 20;
    localparam int LPW_FAST_WAKE_CYC = 3;
    localparam int LPW_SLEEP_WAKE_CYC = 499;
    localparam int LPW_DEEP_WAKE_CYC = 500;
    localparam int LPW_DEEP_WAKE_1TO1_CYC = 100;

    // AXI4-Lite responses.
    localparam logic [1:0] LPW_RESP_OKAY = 2'h0;
    localparam logic [1:0] LPW_RESP_SLVERR = 2'h2;

    typedef enum logic [6:0] {
        LPW_ST_NORM_HI = 7'h01,
        LPW_ST_NORM_LO = 7'h02,
        LPW_ST_DOZE = 7'h04,
        LPW_ST_SLEEP = 7'h08,
        LPW_ST_DEEP = 7'h10,
        LPW_ST_PDOWN = 7'h20,
        LPW_ST_WAKE = 7'h40
    } lpw_state_e;

    typedef struct packed {
        logic awvalid;
        logic [3:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [3:0] araddr;
        logic rready;
    } lpw_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lpw_axi_rsp_s;

endpackage

// *** hw/lpw_ctrl.sv ***
// Purpose: Low-power mode sequencer with wake-up and timer-expiry handling.
// Assumes: Inputs synchronous to clk; clk stands for the keep-alive oscillator clock.
// Notes: Software reaches the mode controls over AXI4-Lite.
// How it works
// - Enabled asynchronous wake clears mode, keeps gear.
// - Wake sources: controller, timers, decrementer.
// - Fast modes wake in three to four cycles.
// - Controller wake request is level sensitive.
// - Timer interrupts set sticky pending status.
// - Gear runs low divider unless interrupted.
// - Fall back to normal-low when quiet.
// - Doze wakes on controller interrupt.
// - Deep-sleep wakes on controller or timers.
// - Deep-sleep PLL off; 500 or 100 clocks.
// - Sleep wakes within 500 oscillator cycles.
// - Doze-high wakes in actual clock cycles.
// - Enabled timer interrupt sets expiry status.
// - Hard reset with clear status sets it.
// - Writing one clears expiry status.
// - Expiry pin driven on enabled timer event.
// - Writing one releases the expiry pin.
// - Execution only in normal modes.
// - Mode field decode including deep versus down.
// - Entry needs enable set and lock clear.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lpw_ctrl
    import lpw_pkg::*;
#(
    parameter int DEEP_WAKE_CYC = LPW_DEEP_WAKE_CYC,
    parameter int DEEP_WAKE_1TO1_CYC = LPW_DEEP_WAKE_1TO1_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire lpw_axi_req_s axi_req,
    output lpw_axi_rsp_s axi_rsp,
    // Wake sources
    input wire logic ctrl_wake_req,
    input wire logic [3:0] timer_event,
    input wire logic hard_reset_pin,
    // Power outputs
    output logic timer_expiry_pin,
    output logic pll_enable,
    output logic sys_clk_enable,
    output logic gear_low_active,
    output logic cpu_run
);

    localparam int WCNT_W = 10;

    initial
    begin
        if (DEEP_WAKE_CYC < 1 || DEEP_WAKE_CYC >= (1 << WCNT_W))
            $error("DEEP_WAKE_CYC out of range");
        if (DEEP_WAKE_1TO1_CYC < 1 || DEEP_WAKE_1TO1_CYC >= (1 << WCNT_W))
            $error("DEEP_WAKE_1TO1_CYC out of range");
    end

    typedef struct packed {
        lpw_state_e st;
        logic [1:0] power_mode_select;
        logic gear_select;
        logic power_mgmt_enable;
        logic mode_lock;
        logic one_to_one;
        logic [3:0] timer_en;
        logic timer_irq_status;
        logic timer_expiry_status;
        logic timer_expiry_pin_pin;
        logic hrst_d1;
        logic [WCNT_W-1:0] wcnt;
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lpw_regs_s;

    lpw_regs_s q;
    lpw_regs_s d;

    logic timer_hit;
    logic async_wake;
    logic wr_fire;
    logic rd_fire;
    logic ctrl_wr;
    logic stat_wr;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_new;
    logic [31:0] stat_word;
    logic normal_mode;

    always_comb
    begin
        // The whole block runs on the keep-alive clock so it still sees wakes in the deep modes.
        timer_hit = |(timer_event & q.timer_en);
        // A pending timer status keeps the wake alive until software clears it.
        async_wake = ctrl_wake_req | timer_hit | q.timer_irq_status;
        normal_mode = (q.st == LPW_ST_NORM_HI) || (q.st == LPW_ST_NORM_LO);
        wmask = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
        wr_fire = q.aw_got && q.w_got && !q.bvalid;
        rd_fire = axi_req.arvalid && !q.rvalid;
        ctrl_wr = wr_fire && (q.aw_addr == LPW_OFS_CTRL);
        stat_wr = wr_fire && (q.aw_addr == LPW_OFS_STAT);
        ctrl_word = '0;
        ctrl_word[LPW_CTRL_MODE_LO +: 2] = q.power_mode_select;
        ctrl_word[LPW_CTRL_GEAR] = q.gear_select;
        ctrl_word[LPW_CTRL_PWR_EN] = q.power_mgmt_enable;
        ctrl_word[LPW_CTRL_LOCK] = q.mode_lock;
        ctrl_word[LPW_CTRL_ONE2ONE] = q.one_to_one;
        ctrl_word[LPW_CTRL_TIMER_EN_LO +: 4] = q.timer_en;
        ctrl_new = (ctrl_word & ~wmask) | (q.w_data & wmask);
        stat_word = '0;
        stat_word[LPW_STAT_TIRQ] = q.timer_irq_status;
        stat_word[LPW_STAT_TIMER_EXPIRY_PIN] = q.timer_expiry_status;
        stat_word[LPW_STAT_STATE_LO +: 7] = q.st;

        d = q;
        d.hrst_d1 = hard_reset_pin;

        // AXI4-Lite write channel: address and data taken in either order.
        if (axi_req.awvalid && !q.aw_got)
        begin
            d.aw_got = 1'b1;
            d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !q.w_got)
        begin
            d.w_got = 1'b1;
            d.w_data = axi_req.wdata;
            d.w_strb = axi_req.wstrb;
        end
        if (wr_fire)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = (q.aw_addr == LPW_OFS_CTRL || q.aw_addr == LPW_OFS_STAT) ? LPW_RESP_OKAY : LPW_RESP_SLVERR;
        end
        if (q.bvalid && axi_req.bready)
            d.bvalid = 1'b0;

        // Read channel.
        if (rd_fire)
        begin
            d.rvalid = 1'b1;
            d.rresp = LPW_RESP_OKAY;
            case (axi_req.araddr)
                LPW_OFS_CTRL: d.rdata = ctrl_word;
                LPW_OFS_STAT: d.rdata = stat_word;
                LPW_OFS_WAKE: d.rdata = {{(32 - WCNT_W){1'b0}}, q.wcnt};
                default:
                begin
                    d.rdata = '0;
                    d.rresp = LPW_RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && axi_req.rready)
            d.rvalid = 1'b0;

        // Control writes. Mode and gear are frozen in doze; mode moves only from normal modes.
        if (ctrl_wr)
        begin
            d.power_mgmt_enable = ctrl_new[LPW_CTRL_PWR_EN];
            d.mode_lock = ctrl_new[LPW_CTRL_LOCK];
            d.one_to_one = ctrl_new[LPW_CTRL_ONE2ONE];
            d.timer_en = ctrl_new[LPW_CTRL_TIMER_EN_LO +: 4];
            if (normal_mode)
            begin
                d.gear_select = ctrl_new[LPW_CTRL_GEAR];
                d.power_mode_select = ctrl_new[LPW_CTRL_MODE_LO +: 2];
            end
        end

        // Write-one clears; a simultaneous event wins over the clear.
        if (stat_wr && q.w_strb[0] && q.w_data[LPW_STAT_TIRQ])
            d.timer_irq_status = 1'b0;
        if (stat_wr && q.w_strb[0] && q.w_data[LPW_STAT_TIMER_EXPIRY_PIN])
        begin
            d.timer_expiry_status = 1'b0;
            d.timer_expiry_pin_pin = 1'b0;
        end
        if (timer_hit)
        begin
            d.timer_irq_status = 1'b1;
            d.timer_expiry_status = 1'b1;
            d.timer_expiry_pin_pin = 1'b1;
        end

        // Mode sequencer.
        case (q.st)
            LPW_ST_NORM_HI, LPW_ST_NORM_LO:
            begin
                // Gear runs low only when nothing is pending and management is on.
                if (q.gear_select && q.power_mgmt_enable && !ctrl_wake_req && !q.timer_irq_status && !timer_hit)
                    d.st = LPW_ST_NORM_LO;
                else
                    d.st = LPW_ST_NORM_HI;
                // Entry only when enabled and unlocked.
                if (q.power_mgmt_enable && !q.mode_lock && !async_wake)
                begin
                    case (q.power_mode_select)
                        LPW_MODE_DOZE: d.st = LPW_ST_DOZE;
                        LPW_MODE_SLEEP: d.st = LPW_ST_SLEEP;
                        LPW_MODE_DEEP: d.st = q.timer_expiry_status ? LPW_ST_DEEP : LPW_ST_PDOWN;
                        default: d.st = d.st;
                    endcase
                end
            end
            LPW_ST_DOZE:
            begin
                // Controller interrupt always ends doze; timers only when enabled.
                if (ctrl_wake_req || timer_hit || q.timer_irq_status)
                begin
                    d.st = LPW_ST_WAKE;
                    d.wcnt = WCNT_W'(LPW_FAST_WAKE_CYC - 1);
                end
            end
            LPW_ST_SLEEP:
            begin
                if (async_wake)
                begin
                    d.st = LPW_ST_WAKE;
                    d.wcnt = WCNT_W'(LPW_FAST_WAKE_CYC - 1);
                end
            end
            LPW_ST_DEEP:
            begin
                if (async_wake)
                begin
                    d.st = LPW_ST_WAKE;
                    // PLL relock time.
                    d.wcnt = q.one_to_one ? WCNT_W'(DEEP_WAKE_1TO1_CYC - 1) : WCNT_W'(DEEP_WAKE_CYC - 1);
                end
            end
            LPW_ST_PDOWN:
            begin
                // Only hard reset leaves power-down.
                if (hard_reset_pin && !q.hrst_d1)
                begin
                    d.timer_expiry_status = 1'b1;
                    d.timer_expiry_pin_pin = 1'b1;
                    d.st = LPW_ST_WAKE;
                    d.wcnt = WCNT_W'(LPW_FAST_WAKE_CYC - 1);
                end
            end
            LPW_ST_WAKE:
            begin
                if (q.wcnt == '0)
                    d.st = LPW_ST_NORM_HI;
                else
                    d.wcnt = q.wcnt - WCNT_W'(1);
            end
            default: d.st = LPW_ST_NORM_HI;
        endcase

        // Leaving any low-power mode clears the mode field but not the gear.
        if (q.st != LPW_ST_WAKE && d.st == LPW_ST_WAKE)
            d.power_mode_select = LPW_MODE_NORMAL;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= LPW_ST_NORM_HI;
            q.timer_en <= LPW_TIMER_EN_RST;
            q.timer_expiry_status <= LPW_TIMER_EXPIRY_PIN_RST;
            q.timer_expiry_pin_pin <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    always_comb
    begin
        axi_rsp.awready = !q.aw_got;
        axi_rsp.wready = !q.w_got;
        axi_rsp.bvalid = q.bvalid;
        axi_rsp.bresp = q.bresp;
        axi_rsp.arready = !q.rvalid;
        axi_rsp.rvalid = q.rvalid;
        axi_rsp.rdata = q.rdata;
        axi_rsp.rresp = q.rresp;
    end

    // External supply logic answers this pin with hard reset.
    assign timer_expiry_pin = q.timer_expiry_pin_pin;
    assign pll_enable = !(q.st == LPW_ST_DEEP || q.st == LPW_ST_PDOWN);
    assign sys_clk_enable = !(q.st inside {LPW_ST_SLEEP, LPW_ST_DEEP, LPW_ST_PDOWN, LPW_ST_WAKE});
    assign gear_low_active = (q.st == LPW_ST_NORM_LO) || (q.st == LPW_ST_DOZE && q.gear_select);
    assign cpu_run = (q.st == LPW_ST_NORM_HI) || (q.st == LPW_ST_NORM_LO);

endmodule

// *** tb/lpw_chk.sv ***
// Purpose: Port assertions for lpw_ctrl.
// Assumes: One clock, rst async active high.
// Notes: Bound to every lpw_ctrl instance.
`timescale 1ns/1ps
module lpw_chk
    import lpw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire lpw_axi_req_s axi_req,
    input wire lpw_axi_rsp_s axi_rsp,
    // Wake and power
    input wire logic ctrl_wake_req,
    input wire logic [3:0] timer_event,
    input wire logic hard_reset_pin,
    input wire logic timer_expiry_pin,
    input wire logic pll_enable,
    input wire logic sys_clk_enable,
    input wire logic gear_low_active,
    input wire logic cpu_run
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_back_run;
        ##[1:5] cpu_run;
    endsequence
    exec_normal_a: assert property (cpu_run |-> pll_enable && sys_clk_enable)
        else $error("core runs in a low-power mode");
    clk_gate_a: assert property (!pll_enable |-> !cpu_run && !sys_clk_enable)
        else $error("clocks live with pll off");
    gear_exit_a: assert property ($rose(ctrl_wake_req) && gear_low_active |-> ##[1:5] !gear_low_active)
        else $error("gear kept during interrupt");
    doze_wake_a: assert property (!cpu_run && sys_clk_enable && ctrl_wake_req |-> s_back_run)
        else $error("doze wake too slow");
    sleep_wake_a: assert property (!sys_clk_enable && pll_enable && ctrl_wake_req |-> s_back_run)
        else $error("sleep wake too slow");
    pin_drop_a: assert property ($fell(timer_expiry_pin) |-> $rose(axi_rsp.bvalid))
        else $error("expiry pin fell without write");
    pin_cause_a: assert property ($rose(timer_expiry_pin) |->
        $past(|timer_event) || $past(hard_reset_pin) || $past(hard_reset_pin, 2))
        else $error("expiry pin rose without cause");
    pdown_exit_a: assert property ($rose(hard_reset_pin) && !pll_enable |-> ##[1:10] cpu_run && timer_expiry_pin)
        else $error("no exit on hard reset");
    bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
        else $error("write response dropped");
    rd_lat_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
endmodule
bind lpw_ctrl lpw_chk i_chk (.clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .ctrl_wake_req(ctrl_wake_req), .timer_event(timer_event), .hard_reset_pin(hard_reset_pin),
    .timer_expiry_pin(timer_expiry_pin), .pll_enable(pll_enable), .sys_clk_enable(sys_clk_enable),
    .gear_low_active(gear_low_active), .cpu_run(cpu_run));

// *** tb/lpw_partner.sv ***
// Purpose: Interrupt controller and supply logic facing lpw_ctrl.
// Assumes: Bench commands are one-cycle pulses.
// Notes: Wake request latency is set per raise.
`timescale 1ns/1ps
module lpw_partner #(parameter int HOLD = 4)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench commands
    input wire logic raise_irq,
    input wire logic clear_irq,
    input wire logic kick_hard_reset_pin,
    input wire logic [3:0] lat,
    // Device side
    input wire logic timer_expiry_pin,
    output logic ctrl_wake_req,
    output logic hard_reset_pin
);
    int dly;
    int hold;
    logic pin_q;
    assign hard_reset_pin = hold != 0;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dly <= 0;
            hold <= 0;
            pin_q <= 1'b0;
            ctrl_wake_req <= 1'b0;
        end
        else
        begin
            if (raise_irq)
                dly <= int'(lat) + 1;
            else if (dly != 0)
                dly <= dly - 1;
            if (dly == 1)
                ctrl_wake_req <= 1'b1;
            // The request is a level that only clearing the cause removes.
            if (clear_irq)
                ctrl_wake_req <= 1'b0;
            pin_q <= timer_expiry_pin;
            // Short hard reset on expiry; a rise during a pulse is not re-armed.
            if (hold != 0)
                hold <= hold - 1;
            else if (kick_hard_reset_pin || (timer_expiry_pin && !pin_q))
                hold <= HOLD;
        end
    end
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for lpw_ctrl.
// Assumes: 20 MHz clock, bench drives on rising edges.
// Notes: Deep wake count shortened to 5 cycles.
`timescale 1ns/1ps
module testbench
    import lpw_pkg::*;
;
    localparam int DW = 5;
    logic clk;
    logic rst;
    lpw_axi_req_s req;
    lpw_axi_rsp_s rsp;
    logic wake, hrst, pin, pll, sclk, gear, run, raise, clr, kick;
    logic [3:0] tev;
    logic [3:0] lat;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [1:0] rc;
    int num_errors, compares, m_stat, cyc, i;
    logic [31:0] ent [3] = '{32'h80B, 32'h80B, 32'h80A};
    // Status word: state one-hot sits at bits 14:8, expiry status bit 1, timer status bit 0.
    logic [31:0] st [3] = '{32'h2000, 32'h1002, 32'h802};
    logic [31:0] aft [3] = '{32'h102, 32'h103, 32'h102};
    int lim [3] = '{12, DW + 6, 8};

    lpw_ctrl #(.DEEP_WAKE_CYC(DW), .DEEP_WAKE_1TO1_CYC(2)) i_dut (.clk(clk), .rst(rst), .axi_req(req),
        .axi_rsp(rsp), .ctrl_wake_req(wake), .timer_event(tev), .hard_reset_pin(hrst),
        .timer_expiry_pin(pin), .pll_enable(pll), .sys_clk_enable(sclk), .gear_low_active(gear), .cpu_run(run));
    lpw_partner i_far (.clk(clk), .rst(rst), .raise_irq(raise), .clear_irq(clr), .kick_hard_reset_pin(kick),
        .lat(lat), .timer_expiry_pin(pin), .ctrl_wake_req(wake), .hard_reset_pin(hrst));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic conclude();
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bound(input int n, input int lim);
        if (n >= lim)
        begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{1'b1, a, 1'b1, d, 4'hF, 1'b1, 1'b0, 4'h0, 1'b0};
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        bound(n, 50);
    endtask

    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        int n;
        @(posedge clk);
        req <= '{1'b0, 4'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) break;
        end
        rd = rsp.rdata;
        rc = rsp.rresp;
        req.rready <= 1'b0;
        bound(n, 50);
        chk(nm, e, rd);
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (cyc = 0; cyc < lim; cyc++)
        begin
            @(posedge clk);
            if (s === v) break;
        end
        bound(cyc, lim);
    endtask

    // One-cycle command pulse: 0 raise, 1 clear, 2 hard reset kick, otherwise decrementer event.
    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            0: raise <= 1'b1;
            1: clr <= 1'b1;
            2: kick <= 1'b1;
            default: tev <= 4'h8;
        endcase
        @(posedge clk);
        {raise, clr, kick} <= 3'h0;
        tev <= 4'h0;
    endtask

    initial
    begin
        rst = 1'b1;
        req = '0;
        tev = '0;
        lat = '0;
        {raise, clr, kick} = 3'h0;
        seed = 32'h5DEB;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rchk("stat", LPW_OFS_STAT, 32'h102);
        chk("run", 1, run);
        rchk("unmapped", 4'hC, 32'h0);
        chk("rresp", LPW_RESP_SLVERR, rc);
        wr(LPW_OFS_STAT, 32'h3);
        chk("pin", 0, pin);
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            wr(LPW_OFS_CTRL, {20'h0, seed[3:0], 8'h0});
            @(posedge clk);
            tev <= 4'h1 << i;
            @(posedge clk);
            tev <= 4'h0;
            @(posedge clk);
            m_stat = seed[i] ? 32'h103 : 32'h100;
            chk("pin", seed[i], pin);
            rchk("stat", LPW_OFS_STAT, m_stat);
            wr(LPW_OFS_STAT, 32'h0);
            rchk("stat", LPW_OFS_STAT, m_stat);
            wr(LPW_OFS_STAT, 32'h3);
            chk("pin", 0, pin);
        end
        for (i = 0; i < 2; i++)
        begin
            wr(LPW_OFS_CTRL, i ? 32'h01 : 32'h19);
            repeat (3) @(posedge clk);
            chk("run", 1, run);
        end
        wr(LPW_OFS_CTRL, 32'hD);
        repeat (2) @(posedge clk);
        chk("run", 0, run);
        chk("gear", 1, gear);
        rchk("stat", LPW_OFS_STAT, 32'h400);
        lat <= seed[7:4];
        pulse(0);
        wait_for(run, 1'b1, 25);
        rchk("ctrl", LPW_OFS_CTRL, 32'hC);
        rchk("stat", LPW_OFS_STAT, 32'h100);
        pulse(1);
        wait_for(gear, 1'b1, 20);
        rchk("stat", LPW_OFS_STAT, 32'h200);
        lat <= 4'h0;
        pulse(0);
        wait_for(gear, 1'b0, 8);
        pulse(1);
        for (i = 0; i < 3; i++)
        begin
            wr(LPW_OFS_CTRL, ent[i]);
            repeat (2) @(posedge clk);
            chk("pll", i == 2, pll);
            rchk("stat", LPW_OFS_STAT, st[i]);
            if (i == 0) pulse(2);
            if (i == 1) pulse(3);
            if (i == 2) pulse(0);
            wait_for(run, 1'b1, lim[i]);
            rchk("ctrl", LPW_OFS_CTRL, 32'h808);
            rchk("stat", LPW_OFS_STAT, aft[i]);
            if (i == 1) wr(LPW_OFS_STAT, 32'h1);
            if (i == 2) pulse(1);
        end
        conclude();
    end
endmodule
